// ==== hdl/imu_map.svh ====
`ifndef IMU_MAP_SVH
`define IMU_MAP_SVH
`define IMU_CTRL_OFS 8'h00
`define IMU_INSTR_OFS 8'h04
`define IMU_STATUS_OFS 8'h08
`define IMU_REGSEL_OFS 8'h0C
`define IMU_REGDATA_OFS 8'h10
`define IMU_MEMADDR_OFS 8'h14
`define IMU_MEMDATA_OFS 8'h18
`define IMU_CTRL_GO_BIT 0
`define IMU_CTRL_OVM_BIT 1
`define IMU_INSTR_PAR_BIT 31
`define IMU_FLAG_C 0
`define IMU_FLAG_V 1
`define IMU_FLAG_Z 2
`define IMU_FLAG_N 3
`define IMU_FLAG_UF 4
`define IMU_FLAG_LV 5
`define IMU_FLAG_LUF 6
`define IMU_NUM_REGS 32
`define IMU_NUM_XREGS 5'd8
`define IMU_AUX_BASE 5'd8
`define IMU_IR0_IDX 5'd16
`define IMU_IR1_IDX 5'd17
`define IMU_MEM_WORDS 16
`define IMU_MEM_AW 4
`define IMU_RESP_OKAY 2'h0
`define IMU_RESP_SLVERR 2'h2
`define IMU_SAT_POS 32'h7FFFFFFF
`define IMU_SAT_NEG 32'h80000000
`endif

// ==== hdl/imu_mul.sv ====
`timescale 1ns/10ps
`include "imu_map.svh"
module imu_mul (
  input wire logic [31:0] a,
  input wire logic [31:0] b,
  input wire logic overflow_mode_bit,
  output logic [47:0] prod,
  output logic [31:0] res,
  output logic ovf
);
  always_comb begin
    prod = $signed(a[23:0]) * $signed(b[23:0]);
    ovf = prod[47:32] != {16{prod[31]}};
    if (ovf && overflow_mode_bit) begin
      res = prod[47] ? `IMU_SAT_NEG : `IMU_SAT_POS;
    end else begin
      res = prod[31:0];
    end
  end
endmodule

// ==== hdl/imu_opnd.sv ====
`timescale 1ns/10ps
`include "imu_map.svh"
module imu_opnd (
  input wire logic [7:0] field,
  input wire logic indirect,
  input wire imu_pkg::imu_rf_type rf,
  input wire imu_pkg::imu_mem_type mem,
  output logic [31:0] value
);
  logic [31:0] disp;
  logic [31:0] ea;
  always_comb begin
    case (field[4:3])
      2'b00: disp = 32'h00000000;
      2'b01: disp = 32'h00000001;
      2'b10: disp = rf[`IMU_IR0_IDX];
      default: disp = rf[`IMU_IR1_IDX];
    endcase
    ea = rf[`IMU_AUX_BASE + {2'b00, field[2:0]}] + disp;
    // only the low address bits reach the small operand store
    if (indirect) begin
      value = mem[ea[`IMU_MEM_AW-1:0]];
    end else begin
      value = rf[field[4:0]];
    end
  end
endmodule

// ==== hdl/imu_pkg.sv ====
`include "imu_map.svh"
package imu_pkg;
  typedef enum logic [1:0] {
    IMU_IDLE = 2'b00,
    IMU_EXEC = 2'b01
  } imu_phase_type;
  typedef logic [`IMU_NUM_REGS-1:0][31:0] imu_rf_type;
  typedef logic [`IMU_MEM_WORDS-1:0][31:0] imu_mem_type;
  typedef struct packed {
    imu_phase_type phase;
    logic [31:0] instr;
    logic overflow_mode_bit;
    logic [6:0] flags;
    logic [4:0] regsel;
    logic [`IMU_MEM_AW-1:0] memaddr;
    imu_rf_type rf;
    imu_mem_type mem;
    logic awready;
    logic wready;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic done;
  } imu_state_type;
endpackage

// ==== hdl/imu_top.sv ====
`timescale 1ns/10ps
`include "imu_map.svh"
module imu_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic exec_done
);
  imu_pkg::imu_state_type c_reg;
  imu_pkg::imu_state_type c_next;
  logic par;
  logic [7:0] fld [4];
  logic ind [4];
  logic [31:0] src [4];
  logic [31:0] mul_a;
  logic [31:0] mul_b;
  logic [31:0] add_x;
  logic [31:0] add_y;
  logic [31:0] add_res;
  logic [47:0] mul_prod;
  logic [31:0] mul_res;
  logic mul_ovf;
  logic [4:0] dst1;
  logic [4:0] dst2;
  logic upd;
  logic exec;
  logic status_wr;
  logic [31:0] wmerged;

  ////////////////////////////////////////////////////////////////////////
  // operand decode and routing
  always_comb begin
    par = c_reg.instr[`IMU_INSTR_PAR_BIT];
    if (par) begin
      fld[0] = {5'h00, c_reg.instr[21:19]};
      fld[1] = {5'h00, c_reg.instr[18:16]};
      fld[2] = c_reg.instr[15:8];
      fld[3] = c_reg.instr[7:0];
      ind[0] = 1'b0;
      ind[1] = 1'b0;
      // the fixed two-register, two-indirect layout relies on the supplier
      ind[2] = 1'b1;
      ind[3] = 1'b1;
      dst1 = {4'h0, c_reg.instr[23]};
      dst2 = {4'h1, c_reg.instr[22]};
    end else begin
      fld[0] = c_reg.instr[15:8];
      fld[1] = c_reg.instr[7:0];
      fld[2] = 8'h00;
      fld[3] = 8'h00;
      ind[0] = c_reg.instr[21];
      ind[1] = c_reg.instr[22];
      ind[2] = 1'b0;
      ind[3] = 1'b0;
      dst1 = c_reg.instr[20:16];
      dst2 = c_reg.instr[20:16];
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_opnd
      imu_opnd u_opnd (
        .field(fld[gi]),
        .indirect(ind[gi]),
        .rf(c_reg.rf),
        .mem(c_reg.mem),
        .value(src[gi])
      );
    end
  endgenerate

  always_comb begin
    if (!par) begin
      mul_a = src[0];
      mul_b = src[1];
      add_x = src[2];
      add_y = src[3];
    end else begin
      case (c_reg.instr[25:24])
        2'b00: begin
          mul_a = src[2];
          mul_b = src[3];
          add_x = src[0];
          add_y = src[1];
        end
        2'b01: begin
          mul_a = src[2];
          mul_b = src[0];
          add_x = src[3];
          add_y = src[1];
        end
        2'b10: begin
          mul_a = src[0];
          mul_b = src[1];
          add_x = src[2];
          add_y = src[3];
        end
        default: begin
          mul_a = src[2];
          mul_b = src[0];
          add_x = src[1];
          add_y = src[3];
        end
      endcase
    end
    add_res = add_x + add_y;
  end

  imu_mul u_mul (
    .a(mul_a),
    .b(mul_b),
    .overflow_mode_bit(c_reg.overflow_mode_bit),
    .prod(mul_prod),
    .res(mul_res),
    .ovf(mul_ovf)
  );

  ////////////////////////////////////////////////////////////////////////
  // bus slave and execute
  always_comb begin
    c_next = c_reg;
    c_next.done = 1'b0;
    exec = c_reg.phase == imu_pkg::IMU_EXEC;
    upd = dst1 < `IMU_NUM_XREGS;
    status_wr = 1'b0;
    wmerged = 32'h00000000;
    if (s_axi_awvalid && c_reg.awready) begin
      c_next.aw_got = 1'b1;
      c_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && c_reg.wready) begin
      c_next.w_got = 1'b1;
      c_next.wdata = s_axi_wdata;
      c_next.wstrb = s_axi_wstrb;
    end
    if (c_reg.bvalid && s_axi_bready) begin
      c_next.bvalid = 1'b0;
    end
    if (c_reg.aw_got && c_reg.w_got && !c_reg.bvalid) begin
      c_next.aw_got = 1'b0;
      c_next.w_got = 1'b0;
      c_next.bvalid = 1'b1;
      c_next.bresp = `IMU_RESP_OKAY;
      case ({c_reg.awaddr[7:2], 2'b00})
        `IMU_CTRL_OFS: wmerged = {30'h00000000, c_reg.overflow_mode_bit, 1'b0};
        `IMU_INSTR_OFS: wmerged = c_reg.instr;
        `IMU_STATUS_OFS: wmerged = {25'h0000000, c_reg.flags};
        `IMU_REGSEL_OFS: wmerged = {27'h0000000, c_reg.regsel};
        `IMU_REGDATA_OFS: wmerged = c_reg.rf[c_reg.regsel];
        `IMU_MEMADDR_OFS: wmerged = {28'h0000000, c_reg.memaddr};
        `IMU_MEMDATA_OFS: wmerged = c_reg.mem[c_reg.memaddr];
        default: wmerged = 32'h00000000;
      endcase
      for (int i = 0; i < 4; i++) begin
        if (c_reg.wstrb[i]) begin
          wmerged[i*8 +: 8] = c_reg.wdata[i*8 +: 8];
        end
      end
      case ({c_reg.awaddr[7:2], 2'b00})
        `IMU_CTRL_OFS: begin
          c_next.overflow_mode_bit = wmerged[`IMU_CTRL_OVM_BIT];
          // a go while executing is dropped: one instruction at a time
          if (wmerged[`IMU_CTRL_GO_BIT] && !exec) begin
            c_next.phase = imu_pkg::IMU_EXEC;
          end
        end
        `IMU_INSTR_OFS: c_next.instr = wmerged;
        `IMU_STATUS_OFS: begin
          c_next.flags = wmerged[6:0];
          status_wr = 1'b1;
        end
        `IMU_REGSEL_OFS: c_next.regsel = wmerged[4:0];
        `IMU_REGDATA_OFS: c_next.rf[c_reg.regsel] = wmerged;
        `IMU_MEMADDR_OFS: c_next.memaddr = wmerged[`IMU_MEM_AW-1:0];
        `IMU_MEMDATA_OFS: c_next.mem[c_reg.memaddr] = wmerged;
        default: c_next.bresp = `IMU_RESP_SLVERR;
      endcase
    end
    c_next.awready = !c_next.aw_got && !c_next.bvalid;
    c_next.wready = !c_next.w_got && !c_next.bvalid;
    if (c_reg.rvalid && s_axi_rready) begin
      c_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && c_reg.arready) begin
      c_next.rvalid = 1'b1;
      c_next.rresp = `IMU_RESP_OKAY;
      case ({s_axi_araddr[7:2], 2'b00})
        `IMU_CTRL_OFS: c_next.rdata = {30'h00000000, c_reg.overflow_mode_bit, exec};
        `IMU_INSTR_OFS: c_next.rdata = c_reg.instr;
        `IMU_STATUS_OFS: c_next.rdata = {25'h0000000, c_reg.flags};
        `IMU_REGSEL_OFS: c_next.rdata = {27'h0000000, c_reg.regsel};
        `IMU_REGDATA_OFS: c_next.rdata = c_reg.rf[c_reg.regsel];
        `IMU_MEMADDR_OFS: c_next.rdata = {28'h0000000, c_reg.memaddr};
        `IMU_MEMDATA_OFS: c_next.rdata = c_reg.mem[c_reg.memaddr];
        default: begin
          c_next.rdata = 32'h00000000;
          c_next.rresp = `IMU_RESP_SLVERR;
        end
      endcase
    end
    c_next.arready = !c_next.rvalid;
    // execute goes last so its writes win over a same-cycle bus write;
    // sticky and kept flags start from the bus-updated value
    if (exec) begin
      c_next.phase = imu_pkg::IMU_IDLE;
      c_next.done = 1'b1;
      c_next.rf[dst1] = mul_res;
      if (par) begin
        c_next.rf[dst2] = add_res;
      end
      if (upd) begin
        c_next.flags[`IMU_FLAG_LV] = c_next.flags[`IMU_FLAG_LV] | mul_ovf;
        c_next.flags[`IMU_FLAG_V] = mul_ovf;
        c_next.flags[`IMU_FLAG_UF] = 1'b0;
        c_next.flags[`IMU_FLAG_N] = par ? 1'b0 : mul_res[31];
        c_next.flags[`IMU_FLAG_Z] = par ? 1'b0 : (mul_res == 32'h00000000);
      end
    end
  end

  // all sources are sampled from c_reg, so a register written by the add
  // is seen by the multiply with its old value
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      c_reg <= '0;
      c_reg.awready <= 1'b1;
      c_reg.wready <= 1'b1;
      c_reg.arready <= 1'b1;
    end else begin
      c_reg <= c_next;
    end
  end

  assign s_axi_awready = c_reg.awready;
  assign s_axi_wready = c_reg.wready;
  assign s_axi_bvalid = c_reg.bvalid;
  assign s_axi_bresp = c_reg.bresp;
  assign s_axi_arready = c_reg.arready;
  assign s_axi_rvalid = c_reg.rvalid;
  assign s_axi_rdata = c_reg.rdata;
  assign s_axi_rresp = c_reg.rresp;
  assign exec_done = c_reg.done;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_mul_write;
    exec |=> c_reg.rf[$past(dst1)] == $past(mul_res);
  endproperty
  a_mul_write: assert property (p_mul_write) else $error("product not written");

  property p_trunc;
    exec && !mul_ovf |=> c_reg.rf[$past(dst1)] == $past(mul_prod[31:0]);
  endproperty
  a_trunc: assert property (p_trunc) else $error("result not low product bits");

  property p_ovf;
    exec && upd |=> c_reg.flags[1] == $past(mul_prod[47:32] != {16{mul_prod[31]}});
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow flag wrong");

  property p_noupd;
    exec && !upd && !status_wr |=> $stable(c_reg.flags);
  endproperty
  a_noupd: assert property (p_noupd) else $error("flags moved for far dest");

  property p_sticky;
    exec && upd && mul_ovf |=> c_reg.flags[5] ##1 (c_reg.flags[5] || $past(status_wr));
  endproperty
  a_sticky: assert property (p_sticky) else $error("latched overflow lost");

  property p_nz;
    exec && upd && !par |=> c_reg.flags[3] == $past(mul_res[31]) && !c_reg.flags[4]
      && c_reg.flags[2] == ($past(mul_res) == 32'h00000000);
  endproperty
  a_nz: assert property (p_nz) else $error("sign or zero flag wrong");

  property p_par_flags;
    exec && par |=> c_reg.flags[4:2] == 3'h0;
  endproperty
  a_par_flags: assert property (p_par_flags) else $error("combined flags not cleared");

  property p_sat;
    exec && mul_ovf && c_reg.overflow_mode_bit |=> c_reg.rf[$past(dst1)][30:0] == {31{!$past(mul_prod[47])}};
  endproperty
  a_sat: assert property (p_sat) else $error("saturation wrong");

  property p_add;
    exec && par |=> c_reg.rf[$past(dst2)] == $past(add_x) + $past(add_y);
  endproperty
  a_add: assert property (p_add) else $error("sum not written");

  property p_one_cycle;
    exec |=> c_reg.phase == imu_pkg::IMU_IDLE && c_reg.done ##1 !c_reg.done;
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("execute not one cycle");

  c_single: cover property (exec && !par);
  c_parallel: cover property (exec && par);
  c_saturate: cover property (exec && mul_ovf && c_reg.overflow_mode_bit);
  c_slverr: cover property (c_reg.rvalid && c_reg.rresp == `IMU_RESP_SLVERR);
endmodule

// ==== tb/imu_axi_master.sv ====
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// register-bus master standing in for the instruction supplier
// payload is inverted once released so a stale value is never taken for a fresh one
module imu_axi_master (
  input wire logic aclk,
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  initial begin
    awaddr = 8'h00;
    awvalid = 1'b0;
    wdata = 32'h0;
    wstrb = 4'hF;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 8'h00;
    arvalid = 1'b0;
    rready = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    fork
      begin
        @(posedge aclk);
        while (!awready) @(posedge aclk);
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      begin
        @(posedge aclk);
        while (!wready) @(posedge aclk);
        wvalid <= 1'b0;
        wdata <= ~d;
      end
    join
    while (!bvalid) @(posedge aclk);
    r = bresp;
    bready <= 1'b0;
  endtask
  // partial-word write: strobe is settled before the request and restored after the answer
  task automatic wrs(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
    output logic [1:0] r);
    wstrb <= s;
    wr(a, d, r);
    wstrb <= 4'hF;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    @(posedge aclk);
    while (!arready) @(posedge aclk);
    arvalid <= 1'b0;
    araddr <= ~a;
    while (!rvalid) @(posedge aclk);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
endmodule

// ==== tb/testbench.sv ====
`timescale 1ns/10ps
`include "imu_map.svh"
module testbench;
  typedef struct {
    logic [31:0] a;
    logic [31:0] b;
    logic overflow_mode_bit;
    logic [31:0] res;
    logic ovf;
  } imu_row_type;
  logic aclk, aresetn, exec_done;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rv, ef;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp, m;
  logic [7:0] s1, s2;
  logic lv;
  int num_errors = 0;
  int check_count = 0;
  logic [3:0] dsp [4] = '{4'h0, 4'h1, 4'h2, 4'h5};
  logic [31:0] cprod [4] = '{32'hFFFFFFB3, 32'hFFFFFFEB, 32'h0000000F, 32'hFFFFFFEB};
  logic [31:0] csum [4] = '{32'h00000008, 32'h00000010, 32'h00000004, 32'h00000010};
  imu_row_type rows [9] = '{
    '{32'h00000005, 32'h00000007, 1'b0, 32'h00000023, 1'b0},
    '{32'h0033C251, 32'h0078B600, 1'b0, 32'hE21D9600, 1'b1},
    '{32'h00FFFFFF, 32'h00000003, 1'b0, 32'hFFFFFFFD, 1'b0},
    '{32'h00000000, 32'h00123456, 1'b0, 32'h00000000, 1'b0},
    '{32'h0033C251, 32'h0078B600, 1'b1, 32'h7FFFFFFF, 1'b1},
    '{32'h00800000, 32'h007FFFFF, 1'b1, 32'h80000000, 1'b1},
    '{32'hFF000002, 32'h00000003, 1'b0, 32'h00000006, 1'b0},
    '{32'h00FF8000, 32'h00010000, 1'b0, 32'h80000000, 1'b0},
    '{32'h00008000, 32'h00010000, 1'b0, 32'h80000000, 1'b1}
  };
  ////////////////////////////////////////////////////////////////////////////////
  imu_top dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .exec_done(exec_done)
  );
  imu_axi_master bus (
    .aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready)
  );
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic setr(input logic [4:0] i, input logic [31:0] v);
    bus.wr(`IMU_REGSEL_OFS, {27'h0, i}, resp);
    bus.wr(`IMU_REGDATA_OFS, v, resp);
  endtask
  task automatic setm(input logic [3:0] a, input logic [31:0] v);
    bus.wr(`IMU_MEMADDR_OFS, {28'h0, a}, resp);
    bus.wr(`IMU_MEMDATA_OFS, v, resp);
  endtask
  task automatic getr(input logic [4:0] i, output logic [31:0] v);
    bus.wr(`IMU_REGSEL_OFS, {27'h0, i}, resp);
    bus.rd(`IMU_REGDATA_OFS, v, resp);
  endtask
  // go is committed when the write answer is seen; the pulse is due one edge later
  task automatic run(input logic [31:0] instr, input logic overflow_mode_bit);
    bus.wr(`IMU_INSTR_OFS, instr, resp);
    bus.wr(`IMU_CTRL_OFS, {30'h0, overflow_mode_bit, 1'b1}, resp);
    @(posedge aclk);
    check({31'h0, exec_done}, 32'h1, "done");
    @(posedge aclk);
    check({31'h0, exec_done}, 32'h0, "done width");
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  initial begin
    #(100 * 20000);
    num_errors++;
    final_report;
  end
  initial begin
    aresetn = 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    setr(8, 32'h4);
    setr(9, 32'hA);
    setr(`IMU_IR0_IDX, 32'h2);
    setr(`IMU_IR1_IDX, 32'h5);
    bus.wr(`IMU_STATUS_OFS, 32'h51, resp);
    lv = 1'b0;
    // the unused path of each source holds a decoy so a wrong decode shows
    foreach (rows[i]) begin
      m = 2'(i % 4);
      setr(1, m[0] ? ~rows[i].a : rows[i].a);
      setr(2, m[1] ? ~rows[i].b : rows[i].b);
      setm(4'h4 + dsp[m], m[0] ? rows[i].a : ~rows[i].a);
      setm(4'hA + dsp[m], m[1] ? rows[i].b : ~rows[i].b);
      s1 = m[0] ? {3'h0, m, 3'h0} : 8'h01;
      s2 = m[1] ? {3'h0, m, 3'h1} : 8'h02;
      run({9'h0, m, 5'h03, s1, s2}, rows[i].overflow_mode_bit);
      getr(3, rv);
      check(rv, rows[i].res, "product");
      lv = lv | rows[i].ovf;
      ef = {25'h0, 1'b1, lv, 1'b0, rows[i].res[31], rows[i].res == 32'h0, rows[i].ovf, 1'b1};
      bus.rd(`IMU_STATUS_OFS, rv, resp);
      check(rv, ef, "flags");
    end
    $display("standalone rows done");
    bus.wr(`IMU_STATUS_OFS, 32'h0C, resp);
    setr(1, 32'h0033C251);
    setr(2, 32'h0078B600);
    run(32'h00140102, 1'b0);
    getr(20, rv);
    check(rv, 32'hE21D9600, "wide dst");
    bus.rd(`IMU_STATUS_OFS, rv, resp);
    check(rv, 32'h0C, "flags kept");
    $display("wide destination done");
    setr(5, 32'h5);
    setm(4'h4, 32'hFFFFFFF9);
    setm(4'hA, 32'hB);
    // src[0] is R2, which the add also writes: the product must see the old value
    for (int p = 0; p < 4; p++) begin
      setr(2, 32'h3);
      bus.wr(`IMU_STATUS_OFS, 32'h5F, resp);
      run({1'b1, 5'h0, p[1:0], 2'b00, 3'h2, 3'h5, 8'h00, 8'h01}, 1'b0);
      getr(0, rv);
      check(rv, cprod[p], "par product");
      getr(2, rv);
      check(rv, csum[p], "par sum");
      bus.rd(`IMU_STATUS_OFS, rv, resp);
      check(rv, 32'h41, "par flags");
    end
    $display("parallel modes done");
    setr(6, 32'h11223344);
    bus.wrs(`IMU_REGDATA_OFS, 32'hAABBCCDD, 4'h5, resp);
    check({30'h0, resp}, {30'h0, `IMU_RESP_OKAY}, "good write");
    getr(6, rv);
    check(rv, 32'h11BB33DD, "byte strobes");
    bus.wr(8'h40, 32'h1, resp);
    check({30'h0, resp}, {30'h0, `IMU_RESP_SLVERR}, "bad write");
    bus.rd(8'h40, rv, resp);
    check({30'h0, resp}, {30'h0, `IMU_RESP_SLVERR}, "bad read");
    check(rv, 32'h0, "bad read data");
    @(posedge aclk);
    aresetn <= 1'b0;
    @(posedge aclk);
    aresetn <= 1'b1;
    getr(3, rv);
    check(rv, 32'h0, "reset reg");
    bus.rd(`IMU_STATUS_OFS, rv, resp);
    check(rv, 32'h0, "reset flags");
    bus.rd(`IMU_CTRL_OFS, rv, resp);
    check(rv, 32'h0, "reset ctrl");
    $display("bus and reset done");
    final_report;
  end
endmodule
